/* hdl/cardbus_io_limit_and_intpin_regs.sv */
`timescale 1ns/10ps
module cardbus_io_limit_and_intpin_regs #(
  parameter int unsigned FUNC_NUM = 0
) (
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  // Configuration access
  input  wire cb_io_intpin_pkg::cfg_req_t    cfg_req_i,
  output logic                               cfg_ack_o,
  output logic [31:0]                        cfg_rdata_o,
  // Controls from neighbouring registers
  input  wire cb_io_intpin_pkg::tie_ctrl_t   tie_ctrl_i,
  input  wire logic [31:0]                   io_base_0_i,
  input  wire logic [31:0]                   io_base_1_i,
  // Cycles to decode
  input  wire cb_io_intpin_pkg::io_cycle_t   pci_io_i,
  input  wire cb_io_intpin_pkg::io_cycle_t   cb_io_i,
  // Decode results and register views
  output logic [1:0]                         pci_claim_o,
  output logic [1:0]                         cb_claim_o,
  output logic [7:0]                         irq_line_o,
  output logic [7:0]                         irq_pin_o
);
  import cb_io_intpin_pkg::*;

  logic [13:0] top_0_r;
  logic [13:0] top_1_r;
  logic [7:0]  line_r;
  logic [7:0]  pin_nxt;
  logic [31:0] rdata_nxt;
  logic        win_en_0;
  logic        win_en_1;

  function automatic logic [31:0] top_view(input logic [13:0] top, input logic sel);
    top_view = {16'h0000, top, 1'b0, sel};
  endfunction

  // Page from base only; top holds no page bits
  function automatic logic win_hit(input logic [31:0] base, input logic [13:0] top,
                                   input io_cycle_t cyc, input logic en);
    win_hit = cyc.valid && en
           && (cyc.addr[PAGE_HI:PAGE_LO] == base[PAGE_HI:PAGE_LO])
           && (cyc.addr[TOP_HI:TOP_LO] >= base[TOP_HI:TOP_LO])
           && (cyc.addr[TOP_HI:TOP_LO] <= top);
  endfunction

  function automatic logic is_top_wr(input cfg_req_t r, input logic [7:0] ofs);
    is_top_wr = r.wr && (r.dw == ofs[7:2]);
  endfunction

  // Writable bits only; read-only lanes are dropped
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      top_0_r <= TOP_RST;
    end else if (is_top_wr(cfg_req_i, OFS_IO_TOP_0)) begin
      if (cfg_req_i.be[0]) begin
        top_0_r[5:0] <= cfg_req_i.wdata[7:2];
      end
      if (cfg_req_i.be[1]) begin
        top_0_r[13:6] <= cfg_req_i.wdata[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      top_1_r <= TOP_RST;
    end else if (is_top_wr(cfg_req_i, OFS_IO_TOP_1)) begin
      if (cfg_req_i.be[0]) begin
        top_1_r[5:0] <= cfg_req_i.wdata[7:2];
      end
      if (cfg_req_i.be[1]) begin
        top_1_r[13:6] <= cfg_req_i.wdata[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      line_r <= LINE_RST;
    end else if (is_top_wr(cfg_req_i, OFS_IRQ_NUMBER) && cfg_req_i.be[0]) begin
      line_r <= cfg_req_i.wdata[7:0];
    end
  end

  // Pin report follows tie settings live
  always_comb begin
    pin_nxt = PIN_A;
    if (tie_ctrl_i.tie_every_pin) begin
      pin_nxt = PIN_A;
    end else if (FUNC_NUM == 0) begin
      pin_nxt = PIN_A;
    end else if (FUNC_NUM == 1) begin
      pin_nxt = tie_ctrl_i.tie_pin_b_to_a ? PIN_A : PIN_B;
    end else if (FUNC_NUM == 2) begin
      pin_nxt = PIN_C;
    end else begin
      pin_nxt = {6'h00, tie_ctrl_i.int_sel} + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_pin_o <= PIN_A;
    end else begin
      irq_pin_o <= pin_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_line_o <= LINE_RST;
    end else begin
      irq_line_o <= line_r;
    end
  end

  // Read mux; upper half of top registers is constant zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (cfg_req_i.dw == OFS_IO_TOP_0[7:2]) begin
      rdata_nxt = top_view(top_0_r, tie_ctrl_i.io_top_sel);
    end else if (cfg_req_i.dw == OFS_IO_TOP_1[7:2]) begin
      rdata_nxt = top_view(top_1_r, tie_ctrl_i.io_top_sel);
    end else if (cfg_req_i.dw == OFS_IRQ_NUMBER[7:2]) begin
      rdata_nxt = {16'h0000, pin_nxt, line_r};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_ack_o   <= cfg_req_i.rd || cfg_req_i.wr;
      cfg_rdata_o <= cfg_req_i.rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Select bit ignored for enable, else sel=1 would open the window at reset
  assign win_en_0 = (io_base_0_i[31:2] != 30'h0) || (top_0_r != TOP_RST);
  assign win_en_1 = (io_base_1_i[31:2] != 30'h0) || (top_1_r != TOP_RST);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pci_claim_o <= 2'b00;
      cb_claim_o  <= 2'b00;
    end else begin
      pci_claim_o[0] <= win_hit(io_base_0_i, top_0_r, pci_io_i, win_en_0);
      pci_claim_o[1] <= win_hit(io_base_1_i, top_1_r, pci_io_i, win_en_1);
      cb_claim_o[0]  <= win_hit(io_base_0_i, top_0_r, cb_io_i, win_en_0);
      cb_claim_o[1]  <= win_hit(io_base_1_i, top_1_r, cb_io_i, win_en_1);
    end
  end

  property p_top_upper_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_req_i.rd && (cfg_req_i.dw == OFS_IO_TOP_0[7:2] || cfg_req_i.dw == OFS_IO_TOP_1[7:2])
      |=> cfg_ack_o && (cfg_rdata_o[31:16] == 16'h0000);
  endproperty
  a_top_upper_zero: assert property (p_top_upper_zero) else $error("top upper half not zero");

  property p_top_low_bits;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.dw == OFS_IO_TOP_1[7:2]
      |=> cfg_rdata_o[1:0] == {1'b0, $past(tie_ctrl_i.io_top_sel)};
  endproperty
  a_top_low_bits: assert property (p_top_low_bits) else $error("top low bits wrong");

  property p_top_write_readback;
    @(posedge clk_sys_i) disable iff (rst_i)
      is_top_wr(cfg_req_i, OFS_IO_TOP_0) && cfg_req_i.be[1:0] == 2'b11 ##1
      cfg_req_i.rd && cfg_req_i.dw == OFS_IO_TOP_0[7:2]
      |=> cfg_rdata_o[15:2] == $past(cfg_req_i.wdata[15:2], 2);
  endproperty
  a_top_write_readback: assert property (p_top_write_readback) else $error("top readback");

  property p_ro_lane_write;
    @(posedge clk_sys_i) disable iff (rst_i)
      is_top_wr(cfg_req_i, OFS_IO_TOP_1) && cfg_req_i.be[1:0] == 2'b00 |=> $stable(top_1_r);
  endproperty
  a_ro_lane_write: assert property (p_ro_lane_write) else $error("read-only lane changed top");

  property p_reset_values;
    @(posedge clk_sys_i) rst_i |=> top_0_r == TOP_RST && top_1_r == TOP_RST && line_r == LINE_RST;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_line_write;
    @(posedge clk_sys_i) disable iff (rst_i)
      is_top_wr(cfg_req_i, OFS_IRQ_NUMBER) && cfg_req_i.be[0]
      |=> ##1 irq_line_o == $past(cfg_req_i.wdata[7:0], 2);
  endproperty
  a_line_write: assert property (p_line_write) else $error("irq number not stored");

  property p_disabled_no_claim;
    @(posedge clk_sys_i) disable iff (rst_i)
      !win_en_0 |=> !pci_claim_o[0] && !cb_claim_o[0];
  endproperty
  a_disabled_no_claim: assert property (p_disabled_no_claim) else $error("claim while off");

  property p_claim_range;
    @(posedge clk_sys_i) disable iff (rst_i)
      pci_claim_o[1] |-> $past(pci_io_i.addr[15:2]) <= $past(top_1_r)
                      && $past(pci_io_i.addr[31:16]) == $past(io_base_1_i[31:16]);
  endproperty
  a_claim_range: assert property (p_claim_range) else $error("claim outside window");

  property p_tie_all;
    @(posedge clk_sys_i) disable iff (rst_i)
      tie_ctrl_i.tie_every_pin |=> irq_pin_o == PIN_A;
  endproperty
  a_tie_all: assert property (p_tie_all) else $error("tie-all pin not A");

  property p_pin_untied;
    @(posedge clk_sys_i) disable iff (rst_i)
      !tie_ctrl_i.tie_every_pin && !tie_ctrl_i.tie_pin_b_to_a && FUNC_NUM < 3
      |=> irq_pin_o == 8'(FUNC_NUM + 1);
  endproperty
  a_pin_untied: assert property (p_pin_untied) else $error("untied pin code wrong");

  c_pci_claim:  cover property (@(posedge clk_sys_i) disable iff (rst_i) pci_claim_o[0]);
  c_cb_claim:   cover property (@(posedge clk_sys_i) disable iff (rst_i) cb_claim_o[1]);
  c_top_write:  cover property (@(posedge clk_sys_i) disable iff (rst_i)
                                is_top_wr(cfg_req_i, OFS_IO_TOP_1));
  c_tie_b:      cover property (@(posedge clk_sys_i) disable iff (rst_i)
                                tie_ctrl_i.tie_pin_b_to_a && !tie_ctrl_i.tie_every_pin);
  c_tie_all:    cover property (@(posedge clk_sys_i) disable iff (rst_i)
                                tie_ctrl_i.tie_every_pin);

  property p_ack_pulse;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_req_i.rd || cfg_req_i.wr |=> cfg_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("request not acknowledged");

  property p_no_req_quiet;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(cfg_req_i.rd || cfg_req_i.wr) |=> !cfg_ack_o && cfg_rdata_o == 32'h0000_0000;
  endproperty
  a_no_req_quiet: assert property (p_no_req_quiet) else $error("answer without request");

  property p_write_rdata_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_req_i.wr |=> cfg_rdata_o == 32'h0000_0000;
  endproperty
  a_write_rdata_zero: assert property (p_write_rdata_zero) else $error("read data on write");

  // Both windows read back the one shared select bit, io_top_sel
  property p_top0_low_bits;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.dw == OFS_IO_TOP_0[7:2]
      |=> cfg_rdata_o[1:0] == {1'b0, $past(tie_ctrl_i.io_top_sel)};
  endproperty
  a_top0_low_bits: assert property (p_top0_low_bits) else $error("top0 low bits wrong");

  property p_top1_write_readback;
    @(posedge clk_sys_i) disable iff (rst_i)
      is_top_wr(cfg_req_i, OFS_IO_TOP_1) && cfg_req_i.be[1:0] == 2'b11 ##1
      cfg_req_i.rd && cfg_req_i.dw == OFS_IO_TOP_1[7:2]
      |=> cfg_rdata_o[15:2] == $past(cfg_req_i.wdata[15:2], 2);
  endproperty
  a_top1_write_readback: assert property (p_top1_write_readback) else $error("top1 readback");

  property p_ro_lane_top0;
    @(posedge clk_sys_i) disable iff (rst_i)
      is_top_wr(cfg_req_i, OFS_IO_TOP_0) && cfg_req_i.be[1:0] == 2'b00 |=> $stable(top_0_r);
  endproperty
  a_ro_lane_top0: assert property (p_ro_lane_top0) else $error("read-only lane changed top0");

  property p_line_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(is_top_wr(cfg_req_i, OFS_IRQ_NUMBER) && cfg_req_i.be[0]) |=> $stable(line_r);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("irq number changed unasked");

  property p_pin_read;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.dw == OFS_IRQ_NUMBER[7:2]
      |=> cfg_rdata_o[15:8] == irq_pin_o && cfg_rdata_o[31:16] == 16'h0000;
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin byte differs from report");

  property p_tie_b;
    @(posedge clk_sys_i) disable iff (rst_i)
      FUNC_NUM == 1 && tie_ctrl_i.tie_pin_b_to_a && !tie_ctrl_i.tie_every_pin
      |=> irq_pin_o == PIN_A;
  endproperty
  a_tie_b: assert property (p_tie_b) else $error("tied pin B not reported as A");

  property p_sel_pin;
    @(posedge clk_sys_i) disable iff (rst_i)
      FUNC_NUM >= 3 && !tie_ctrl_i.tie_every_pin
      |=> irq_pin_o == {6'h00, $past(tie_ctrl_i.int_sel)} + 8'h01;
  endproperty
  a_sel_pin: assert property (p_sel_pin) else $error("selected pin code wrong");

  property p_disabled_no_claim_1;
    @(posedge clk_sys_i) disable iff (rst_i)
      !win_en_1 |=> !pci_claim_o[1] && !cb_claim_o[1];
  endproperty
  a_disabled_no_claim_1: assert property (p_disabled_no_claim_1) else $error("claim while off");

  property p_claim_range_0;
    @(posedge clk_sys_i) disable iff (rst_i)
      pci_claim_o[0] |-> $past(pci_io_i.addr[15:2]) >= $past(io_base_0_i[15:2])
                      && $past(pci_io_i.addr[15:2]) <= $past(top_0_r);
  endproperty
  a_claim_range_0: assert property (p_claim_range_0) else $error("claim outside window 0");

  property p_cb_claim_page;
    @(posedge clk_sys_i) disable iff (rst_i)
      cb_claim_o[0] |-> $past(cb_io_i.addr[31:16]) == $past(io_base_0_i[31:16]);
  endproperty
  a_cb_claim_page: assert property (p_cb_claim_page) else $error("claim in wrong page");

  property p_claim_needs_valid;
    @(posedge clk_sys_i) disable iff (rst_i)
      !pci_io_i.valid |=> pci_claim_o == 2'b00;
  endproperty
  a_claim_needs_valid: assert property (p_claim_needs_valid) else $error("claim without cycle");

endmodule

/* hdl/cb_io_intpin_pkg.sv */
package cb_io_intpin_pkg;

  // Byte offsets of the configuration dwords, and of the pin byte within the interrupt dword
  localparam logic [7:0] OFS_IO_TOP_0   = 8'h30;
  localparam logic [7:0] OFS_IO_TOP_1   = 8'h38;
  localparam logic [7:0] OFS_IRQ_NUMBER = 8'h3c;
  localparam logic [7:0] OFS_IRQ_PIN    = 8'h3d;

  // Field layout
  localparam int TOP_LO      = 2;
  localparam int TOP_HI      = 15;
  localparam int PAGE_LO     = 16;
  localparam int PAGE_HI     = 31;
  localparam int PIN_BYTE_LO = 8;

  // Reset values
  localparam logic [13:0] TOP_RST   = 14'h0000;
  localparam logic [7:0]  LINE_RST  = 8'hff;

  // Pin codes
  localparam logic [7:0] PIN_A = 8'h01;
  localparam logic [7:0] PIN_B = 8'h02;
  localparam logic [7:0] PIN_C = 8'h03;

  // Configuration access from the PCI target front end
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:2]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Tie and select bits held in other configuration registers
  typedef struct packed {
    logic       tie_pin_b_to_a;
    logic       tie_every_pin;
    logic       io_top_sel;
    logic [1:0] int_sel;
  } tie_ctrl_t;

  // One I/O cycle offered for decode
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } io_cycle_t;

endpackage

/* bench/cfg_host_model.sv */
`timescale 1ns/10ps
module cfg_host_model (
  // Clock
  input  wire logic                   clk_sys_i,
  // Configuration port of the device
  output cb_io_intpin_pkg::cfg_req_t  cfg_req_o,
  input  wire logic                   cfg_ack_i,
  input  wire logic [31:0]            cfg_rdata_i
);
  import cb_io_intpin_pkg::*;

  initial begin
    cfg_req_o = '0;
  end

  // Idle clears rd and wr and inverts the leftover fields; a second idle in a row restores the last request's fields
  task automatic idle(input int n);
    cfg_req_o = '{rd: 1'b0, wr: 1'b0, dw: ~cfg_req_o.dw, be: ~cfg_req_o.be,
                  wdata: ~cfg_req_o.wdata};
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask

  // Random gaps give both prompt and slow hosts; gap 0 is back to back
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ack);
    int gap;
    gap = $urandom_range(0, 2);
    if (gap > 0) idle(gap);
    cfg_req_o = '{rd: !wr, wr: wr, dw: dw, be: be, wdata: wd};
    @(posedge clk_sys_i);
    #1;
    ack = cfg_ack_i;
    rd = cfg_rdata_i;
  endtask
endmodule

/* bench/cardbus_io_limit_and_intpin_regs_tb.sv */
`timescale 1ns/10ps
module cardbus_io_limit_and_intpin_regs_tb;
  import cb_io_intpin_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  cfg_req_t    req;
  logic        ack;
  logic [31:0] rdata;
  tie_ctrl_t   tie       = '0;
  logic [31:0] base0     = '0;
  logic [31:0] base1     = '0;
  io_cycle_t   pci_io    = '0;
  io_cycle_t   cb_io     = '0;
  logic [1:0]  pci_claim;
  logic [1:0]  cb_claim;
  logic [7:0]  line;
  logic [7:0]  pin [6];
  logic [15:2] top_m [2] = '{default: '0};
  logic [7:0]  line_m    = 8'hff;
  int          n_fail    = 0;
  int          tests_run = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  cardbus_io_limit_and_intpin_regs #(.FUNC_NUM(0)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cfg_req_i(req), .cfg_ack_o(ack), .cfg_rdata_o(rdata), .tie_ctrl_i(tie),
    .io_base_0_i(base0), .io_base_1_i(base1), .pci_io_i(pci_io), .cb_io_i(cb_io),
    .pci_claim_o(pci_claim), .cb_claim_o(cb_claim), .irq_line_o(line), .irq_pin_o(pin[0]));
  for (genvar g = 1; g < 6; g++) begin : g_fn
    cardbus_io_limit_and_intpin_regs #(.FUNC_NUM(g)) i_fn (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .cfg_req_i(req), .cfg_ack_o(), .cfg_rdata_o(), .tie_ctrl_i(tie),
      .io_base_0_i(base0), .io_base_1_i(base1), .pci_io_i(pci_io), .cb_io_i(cb_io),
      .pci_claim_o(), .cb_claim_o(), .irq_line_o(), .irq_pin_o(pin[g]));
  end
  cfg_host_model i_host (.clk_sys_i(clk_sys_i), .cfg_req_o(req), .cfg_ack_i(ack),
    .cfg_rdata_i(rdata));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                      input logic [31:0] wd, input logic [31:0] exp);
    logic [31:0] rd;
    logic        a;
    i_host.access(wr, dw, be, wd, rd, a);
    check({31'h0, a}, 32'h1);
    check(rd, wr ? 32'h0 : exp);
  endtask

  function automatic logic [31:0] top_exp(int w);
    return {16'h0, top_m[w], 1'b0, tie.io_top_sel};
  endfunction

  function automatic logic [7:0] pin_exp(int f, tie_ctrl_t t);
    if (t.tie_every_pin) return PIN_A;
    if (f >= 3) return {6'h0, t.int_sel} + 8'h01;
    if (f == 1) return t.tie_pin_b_to_a ? PIN_A : PIN_B;
    return (f == 2) ? PIN_C : PIN_A;
  endfunction

  function automatic logic hit(logic [31:0] b, logic [15:2] t, logic [31:0] a);
    return (b[31:2] != 0 || t != 0) && a[31:16] == b[31:16] && a[15:2] >= b[15:2]
           && a[15:2] <= t;
  endfunction

  task automatic decode(input logic [31:0] pa, input logic [31:0] ca);
    // Drop the held request so the last write is not applied again
    i_host.idle(0);
    pci_io = '{valid: 1'b1, addr: pa};
    cb_io = '{valid: 1'b1, addr: ca};
    @(posedge clk_sys_i);
    #1;
    pci_io.valid = 1'b0;
    cb_io.valid = 1'b0;
    check({30'h0, pci_claim}, {30'h0, hit(base1, top_m[1], pa), hit(base0, top_m[0], pa)});
    check({30'h0, cb_claim}, {30'h0, hit(base1, top_m[1], ca), hit(base0, top_m[0], ca)});
  endtask

  task automatic complete_run();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(4 * 20000);
    n_fail++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    logic [3:0]  be;
    int          w;
    d = $urandom(32'ha3ca);
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check({24'h0, line}, 32'hff);
    xfer(1'b0, 6'h0c, 4'hf, 32'h0, top_exp(0));
    tie.io_top_sel = 1'b1;
    xfer(1'b0, 6'h0e, 4'hf, 32'h0, top_exp(1));
    xfer(1'b0, 6'h0f, 4'hf, 32'h0, {16'h0, PIN_A, 8'hff});
    decode(32'h0, 32'h4);
    for (int i = 0; i < 12; i++) begin
      w = i % 2;
      d = (i < 2) ? 32'hffffffff : $urandom();
      be = (i < 2) ? 4'hf : 4'($urandom());
      xfer(1'b1, w ? 6'h0e : 6'h0c, be, d, 32'h0);
      if (be[0]) top_m[w][7:2] = d[7:2];
      if (be[1]) top_m[w][15:8] = d[15:8];
      tie.io_top_sel = d[20];
      xfer(1'b0, w ? 6'h0e : 6'h0c, 4'hf, 32'h0, top_exp(w));
    end
    d = $urandom();
    xfer(1'b1, 6'h0f, 4'h3, d, 32'h0);
    line_m = d[7:0];
    xfer(1'b1, 6'h10, 4'hf, d, 32'h0);
    xfer(1'b0, 6'h10, 4'hf, 32'h0, 32'h0);
    xfer(1'b0, 6'h0f, 4'hf, 32'h0, {16'h0, PIN_A, line_m});
    i_host.idle(1);
    check({24'h0, line}, {24'h0, line_m});
    for (int k = 0; k < 16; k++) begin
      tie = '{tie_pin_b_to_a: k[0], tie_every_pin: k[1], io_top_sel: k[0], int_sel: k[3:2]};
      i_host.idle(2);
      for (int f = 0; f < 6; f++) check({24'h0, pin[f]}, {24'h0, pin_exp(f, tie)});
      xfer(1'b0, 6'h0f, 4'hf, 32'h0, {16'h0, pin_exp(0, tie), line_m});
    end
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) begin
        d = $urandom();
        xfer(1'b1, 6'h0c, 4'h3, d, 32'h0);
        xfer(1'b1, 6'h0e, 4'h3, ~d, 32'h0);
        top_m[0] = d[15:2];
        top_m[1] = ~d[15:2];
        base0 = {d[31:16], d[15:2] - 14'($urandom_range(0, 15)), 2'b00};
        base1 = {d[31:16], 16'h0};
      end
      d = {base0[31:16] ^ {15'h0, i % 5 == 0}, 16'h0};
      d[15:2] = top_m[0] + 14'($urandom_range(0, 2)) - 14'h1;
      decode(d, {d[31:16], base0[15:2] + 14'($urandom_range(0, 2)) - 14'h1, 2'($urandom())});
    end
    rst_i = 1'b1;
    i_host.idle(2);
    rst_i = 1'b0;
    top_m = '{default: '0};
    xfer(1'b0, 6'h0e, 4'hf, 32'h0, top_exp(1));
    check({24'h0, line}, 32'hff);
    complete_run();
  end
endmodule
